/* File: swu_dev.sv */
// node end of the single wire link: autobaud receiver, crc and node
// check, write queue, delayed read reply on the shared line
// assumes the line and select pins are synchronous to i_clk
`timescale 1ns/1ps
`include "swu_defines.svh"
module swu_dev import swu_pkg::*; #(
    parameter int FD = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    swu_if.dev bus,
    input wire logic i_node_sel_bit0_pin,
    input wire logic i_node_sel_bit1_pin,
    input wire logic [3:0] i_reply_delay_setting,
    output logic [6:0] o_rd_addr,
    input wire logic [31:0] i_rd_data,
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    output logic [6:0] o_wr_reg,
    output logic [31:0] o_wr_data,
    output logic [7:0] o_dgram_cnt
);
    swu_dev_s_t s;
    swu_dev_s_t n;
    logic line;
    logic fall;
    logic tick;
    logic [7:0] node_select_code;
    logic [7:0] dly;
    logic [63:0] rep;
    logic fifo_ready;

    assign line = bus.single_wire_data_pin;
    assign fall = s.prev & ~line;
    assign tick = s.tmr == 16'h0000;
    // only codes 0..3 exist, so the master code can never match
    assign node_select_code = {6'h00, i_node_sel_bit1_pin, i_node_sel_bit0_pin};
    // setting 0 behaves as 1 so the reply never starts at once
    assign dly = (i_reply_delay_setting == 4'h0) ? `SWU_DELAY_UNIT
               : 8'(i_reply_delay_setting) * `SWU_DELAY_UNIT;
    assign bus.dev_out = s.txs[0];
    assign bus.dev_oe = s.oe;
    assign o_rd_addr = s.rd_addr;
    assign o_dgram_cnt = s.cnt;

    // write datagrams queue here; a full queue stalls the receiver
    swu_fifo #(
        .W(39),
        .D(FD)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(s.st == D_PUSH),
        .o_ready(fifo_ready),
        .i_data({s.reg_a, s.data}),
        .o_valid(o_wr_valid),
        .i_ready(i_wr_ready),
        .o_data({o_wr_reg, o_wr_data})
    );

    // reply frame, crc over the seven bytes in front of it
    always_comb begin
        rep = {`SWU_SYNC_BYTE, `SWU_MASTER_ADDR, 1'b0, s.rd_addr, i_rd_data, 8'h00};
        rep[7:0] = swu_crc(rep, 4'h7);
    end

    // next-state logic of the whole node
    always_comb begin
        n = s;
        n.prev = line;
        n.tmr = tick ? s.blen - 16'h0001 : s.tmr - 16'h0001;
        case (s.st)
            D_IDLE: begin
                n.oe = 1'b0;
                // every datagram starts a fresh baud measurement
                if (fall) begin
                    n.st = D_MEAS;
                    n.meas = 18'h0_0001;
                    n.nfall = 2'h1;
                end
            end
            D_MEAS: begin
                n.meas = s.meas + 18'h0_0001;
                if (!s.prev && line && s.nfall == 2'h1 && s.meas < `SWU_GLITCH_CYC) begin
                    n.st = D_RECOV; // short pulse on idle line is a glitch
                    n.bc = 8'h00;
                end else if (fall && s.nfall == 2'h2) begin
                    // start fall to bit2/bit3 fall spans four bit times
                    n.blen = s.meas[17:2];
                    n.tmr = {1'b0, s.meas[17:3]};
                    n.nbit = 4'h3;
                    n.sh = `SWU_SYNC_PRELOAD;
                    n.nbyte = 3'h0;
                    n.crc = 8'h00;
                    n.st = D_BITS;
                end else if (fall) begin
                    n.nfall = s.nfall + 2'h1;
                end else if (&s.meas) begin
                    n.st = D_RECOV;
                    n.bc = 8'h00;
                end
            end
            D_BITS: begin
                if (tick) begin
                    n.sh = {line, s.sh[7:1]};
                    n.nbit = s.nbit + 4'h1;
                    if (s.nbit == 4'h7) begin
                        n.st = D_STOP;
                    end
                end
            end
            D_STOP: begin
                if (tick) begin
                    if (!line) begin
                        n.st = D_RECOV; // framing error, missing stop
                        n.bc = 8'h00;
                    end else if ((s.nbyte == `SWU_RD_LAST && !s.rw)
                                 || s.nbyte == `SWU_WR_LAST) begin
                        if (s.sh != s.crc) begin
                            n.st = D_RECOV; // bad crc resyncs like any error
                            n.bc = 8'h00;
                        end else if (!s.hit) begin
                            n.st = D_IDLE;
                        end else if (s.rw) begin
                            n.st = D_PUSH;
                        end else begin
                            n.st = D_DELAY;
                            n.bc = 8'h00;
                            n.rd_addr = s.reg_a;
                        end
                    end else begin
                        n.crc = swu_crc_step(s.crc, s.sh);
                        if (s.nbyte == 3'h1) begin
                            n.hit = s.sh == node_select_code;
                        end
                        if (s.nbyte == 3'h2) begin
                            n.rw = s.sh[`SWU_RW_BIT];
                            n.reg_a = s.sh[6:0];
                        end
                        if (s.nbyte >= 3'h3) begin
                            n.data = {s.data[23:0], s.sh};
                        end
                        n.nbyte = s.nbyte + 3'h1;
                        n.bc = 8'h09; // about nine bits since this start
                        n.st = D_GAP;
                    end
                end
            end
            D_GAP: begin
                if (fall) begin
                    n.tmr = s.blen + (s.blen >> 1);
                    n.nbit = 4'h0;
                    n.st = D_BITS;
                end else if (tick) begin
                    n.bc = s.bc + 8'h01;
                    if (s.bc >= `SWU_GAP_BITS) begin
                        n.st = D_RECOV;
                        n.bc = 8'h00;
                    end
                end
            end
            D_RECOV: begin
                // any low restarts the idle count
                if (!line) begin
                    n.bc = 8'h00;
                end else if (tick) begin
                    n.bc = s.bc + 8'h01;
                    if (s.bc == `SWU_RECOV_BITS - 8'h01) begin
                        n.st = D_IDLE;
                    end
                end
            end
            D_PUSH: begin
                // line is ignored while the queue is full
                if (fifo_ready) begin
                    n.cnt = s.cnt + 8'h01;
                    n.st = D_IDLE;
                end
            end
            D_DELAY: begin
                if (tick) begin
                    n.bc = s.bc + 8'h01;
                    if (s.bc == dly - 8'h01) begin
                        n.st = D_TX;
                        n.oe = 1'b1;
                        n.txs = {1'b1, rep[63:56], 1'b0};
                        n.txb = {rep[55:0], 8'h00};
                        n.nbit = 4'h0;
                        n.nbyte = 3'h0;
                    end
                end
            end
            D_TX: begin
                if (tick) begin
                    n.txs = {1'b1, s.txs[9:1]};
                    n.nbit = s.nbit + 4'h1;
                    if (s.nbit == 4'h9) begin
                        n.nbit = 4'h0;
                        if (s.nbyte == `SWU_WR_LAST) begin
                            n.st = D_TAIL;
                            n.bc = 8'h00;
                        end else begin
                            n.nbyte = s.nbyte + 3'h1;
                            n.txs = {1'b1, s.txb[63:56], 1'b0};
                            n.txb = {s.txb[55:0], 8'h00};
                        end
                    end
                end
            end
            D_TAIL: begin
                // drive idle high a while so the master sees a clean end
                if (tick) begin
                    n.bc = s.bc + 8'h01;
                    if (s.bc == `SWU_TAIL_BITS - 8'h01) begin
                        n.oe = 1'b0;
                        n.st = D_IDLE;
                    end
                end
            end
            default: begin
                n.st = D_IDLE;
            end
        endcase
    end

    // one register for all node state except the write queue, which u_fifo holds
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
            s.st <= D_IDLE;
            s.prev <= 1'b1;
            s.blen <= `SWU_BLEN_RESET;
            s.tmr <= `SWU_BLEN_RESET;
            s.txs <= 10'h3FF;
        end else begin
            s <= n;
        end
    end
endmodule

/* File: swu_defines.svh */
// constants of the single wire read link: frame, crc, timing
// assumes one 40 MHz clock; included by the package, swu_dev and swu_host
`ifndef SWU_DEFINES_SVH
`define SWU_DEFINES_SVH
`define SWU_CLK_PERIOD_NS 25
`define SWU_SYNC_BYTE 8'h05
`define SWU_MASTER_ADDR 8'hFF
`define SWU_CRC_POLY 8'h07
`define SWU_RW_BIT 7
`define SWU_RD_LAST 3'h3
`define SWU_WR_LAST 3'h7
`define SWU_GLITCH_CYC 18'h0_0010
`define SWU_BLEN_RESET 16'h0010
`define SWU_SYNC_PRELOAD 8'hA0
`define SWU_GAP_BITS 8'h3F
`define SWU_RECOV_BITS 8'h0C
`define SWU_TAIL_BITS 8'h04
`define SWU_DELAY_UNIT 8'h08
`define SWU_HOST_BIT_NS 4000
`define SWU_HOST_BIT_CYC (`SWU_HOST_BIT_NS / `SWU_CLK_PERIOD_NS)
`define SWU_HOST_TIMEOUT_BITS 8'hC8
`endif

/* File: swu_pkg.sv */
// types and the crc helper shared by both ends of the link
// assumes swu_defines.svh is on the include path
package swu_pkg;
`include "swu_defines.svh"

typedef enum logic [3:0] {
    D_IDLE, D_MEAS, D_BITS, D_STOP, D_GAP, D_RECOV, D_PUSH, D_DELAY, D_TX, D_TAIL
} swu_dev_st_t;

typedef enum logic [2:0] {H_IDLE, H_TX, H_WAIT, H_BITS, H_STOP} swu_host_st_t;

typedef struct packed {
    swu_dev_st_t st;
    logic prev;
    logic [15:0] blen;
    logic [17:0] meas;
    logic [15:0] tmr;
    logic [1:0] nfall;
    logic [3:0] nbit;
    logic [2:0] nbyte;
    logic [7:0] bc;
    logic [7:0] sh;
    logic [7:0] crc;
    logic hit;
    logic rw;
    logic [6:0] reg_a;
    logic [31:0] data;
    logic [63:0] txb;
    logic [9:0] txs;
    logic oe;
    logic [7:0] cnt;
    logic [6:0] rd_addr;
} swu_dev_s_t;

typedef struct packed {
    swu_host_st_t st;
    logic prev;
    logic [15:0] tmr;
    logic [63:0] txb;
    logic [9:0] txs;
    logic [3:0] nbit;
    logic [2:0] nbyte;
    logic [2:0] nlast;
    logic rw;
    logic oe;
    logic [7:0] bc;
    logic [7:0] sh;
    logic [63:0] rxd;
    logic rsp_valid;
    logic rsp_err;
    logic [31:0] rsp_data;
} swu_host_s_t;

// one byte through the crc, lsb first
function automatic logic [7:0] swu_crc_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int j = 0; j < 8; j++) begin
        r = (r[7] ^ b[j]) ? ({r[6:0], 1'b0} ^ `SWU_CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
endfunction

// crc over the first n bytes of v, first byte in the top bits
function automatic logic [7:0] swu_crc(input logic [63:0] v, input logic [3:0] n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
        if (i < int'(n)) begin
            r = swu_crc_step(r, v[63-8*i -: 8]);
        end
    end
    return r;
endfunction
endpackage

/* File: swu_if.sv */
// the shared data line between master and node
// each end drives its own value and enable; the wire is resolved here
`timescale 1ns/1ps
interface swu_if;
    logic dev_out;
    logic dev_oe;
    logic host_out;
    logic host_oe;
    logic single_wire_data_pin;

    // pulled high when nobody drives, wired-and when both do
    assign single_wire_data_pin = (dev_oe ? dev_out : 1'b1) & (host_oe ? host_out : 1'b1);

    modport dev (output dev_out, output dev_oe, input single_wire_data_pin);
    modport host (output host_out, output host_oe, input single_wire_data_pin);
endinterface

/* File: swu_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock; depth need not be a power of two
`timescale 1ns/1ps
module swu_fifo import swu_pkg::*; #(
    parameter int W = 39,
    parameter int D = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } swu_fifo_s_t;

    swu_fifo_s_t s;
    swu_fifo_s_t n;
    logic [W-1:0] mem [D];
    logic push;
    logic pop;

    // full and empty come straight from the fill count
    assign o_ready = s.cnt != (AW+1)'(D);
    assign o_valid = s.cnt != '0;
    assign o_data = mem[s.rp];
    assign push = i_valid & o_ready;
    assign pop = o_valid & i_ready;

    // pointers wrap at depth, count moves by push minus pop
    always_comb begin
        n = s;
        if (push) begin
            n.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + AW'(1);
        end
        if (pop) begin
            n.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + AW'(1);
        end
        n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // storage needs no reset, reads only ever see written entries
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[s.wp] <= i_data;
        end
    end
endmodule

/* File: swu_host.sv */
// master end: sends read or write datagrams at a fixed baud and
// collects the eight byte reply of a read
// assumes one command at a time from the user side
`timescale 1ns/1ps
`include "swu_defines.svh"
module swu_host import swu_pkg::*; #(
    parameter int BIT_CYC = `SWU_HOST_BIT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    swu_if.host bus,
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic i_cmd_write,
    input wire logic [7:0] i_cmd_node,
    input wire logic [6:0] i_cmd_reg,
    input wire logic [31:0] i_cmd_data,
    output logic o_rsp_valid,
    output logic o_rsp_err,
    output logic [31:0] o_rsp_data
);
    swu_host_s_t s;
    swu_host_s_t n;
    logic line;
    logic tick;
    logic [63:0] req;
    logic [63:0] full;

    assign line = bus.single_wire_data_pin;
    assign tick = s.tmr == 16'h0000;
    assign bus.host_out = s.txs[0];
    assign bus.host_oe = s.oe;
    assign o_cmd_ready = s.st == H_IDLE;
    assign o_rsp_valid = s.rsp_valid;
    assign o_rsp_err = s.rsp_err;
    assign o_rsp_data = s.rsp_data;

    // datagram images, first byte on top
    always_comb begin
        if (i_cmd_write) begin
            req = {`SWU_SYNC_BYTE, i_cmd_node, 1'b1, i_cmd_reg, i_cmd_data, 8'h00};
            req[7:0] = swu_crc(req, 4'h7);
        end else begin
            req = {`SWU_SYNC_BYTE, i_cmd_node, 1'b0, i_cmd_reg, 8'h00, 32'h0000_0000};
            req[39:32] = swu_crc(req, 4'h3);
        end
        full = {s.rxd[55:0], s.sh};
    end

    always_comb begin
        n = s;
        n.prev = line;
        n.rsp_valid = 1'b0;
        n.tmr = tick ? 16'(BIT_CYC - 1) : s.tmr - 16'h0001;
        case (s.st)
            H_IDLE: begin
                if (i_cmd_valid) begin
                    n.st = H_TX;
                    n.oe = 1'b1;
                    n.rw = i_cmd_write;
                    n.nlast = i_cmd_write ? `SWU_WR_LAST : `SWU_RD_LAST;
                    n.txs = {1'b1, req[63:56], 1'b0};
                    n.txb = {req[55:0], 8'h00};
                    n.nbit = 4'h0;
                    n.nbyte = 3'h0;
                    n.tmr = 16'(BIT_CYC - 1);
                end
            end
            H_TX: begin
                if (tick) begin
                    n.txs = {1'b1, s.txs[9:1]};
                    n.nbit = s.nbit + 4'h1;
                    if (s.nbit == 4'h9) begin
                        n.nbit = 4'h0;
                        n.nbyte = s.nbyte + 3'h1;
                        n.txs = {1'b1, s.txb[63:56], 1'b0};
                        n.txb = {s.txb[55:0], 8'h00};
                        if (s.nbyte == s.nlast) begin
                            n.oe = 1'b0;
                            n.txs = 10'h3FF;
                            n.nbyte = 3'h0;
                            n.bc = 8'h00;
                            n.st = s.rw ? H_IDLE : H_WAIT;
                        end
                    end
                end
            end
            H_WAIT: begin
                // receiver runs only after our own bytes are out
                if (s.prev && !line) begin
                    n.tmr = 16'(BIT_CYC + BIT_CYC / 2 - 1);
                    n.nbit = 4'h0;
                    n.st = H_BITS;
                end else if (tick) begin
                    n.bc = s.bc + 8'h01;
                    if (s.bc == `SWU_HOST_TIMEOUT_BITS) begin
                        n.rsp_valid = 1'b1;
                        n.rsp_err = 1'b1;
                        n.st = H_IDLE;
                    end
                end
            end
            H_BITS: begin
                if (tick) begin
                    n.sh = {line, s.sh[7:1]};
                    n.nbit = s.nbit + 4'h1;
                    if (s.nbit == 4'h7) begin
                        n.st = H_STOP;
                    end
                end
            end
            H_STOP: begin
                if (tick) begin
                    n.rxd = full;
                    n.nbyte = s.nbyte + 3'h1;
                    n.bc = 8'h00;
                    n.st = H_WAIT;
                    if (!line || s.nbyte == `SWU_WR_LAST) begin
                        n.rsp_valid = 1'b1;
                        n.rsp_err = !line || swu_crc(full, 4'h7) != s.sh
                                    || full[59:56] != 4'(`SWU_SYNC_BYTE)
                                    || full[55:48] != `SWU_MASTER_ADDR;
                        n.rsp_data = full[39:8];
                        n.st = H_IDLE;
                    end
                end
            end
            default: begin
                n.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
            s.st <= H_IDLE;
            s.prev <= 1'b1;
            s.txs <= 10'h3FF;
        end else begin
            s <= n;
        end
    end
endmodule

/* File: swu_props.sv */
// assertions on the shared line between master and node
// assumes BIT equals the master bit length in clock cycles
`timescale 1ns/1ps
module swu_props #(
    parameter int BIT = 20
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic dev_out,
    input wire logic dev_oe,
    input wire logic host_out,
    input wire logic host_oe,
    input wire logic single_wire_data_pin
);
    localparam logic [9:0] FRAME0 = 10'h020A; // start, sync 0x05 lsb first, stop
    logic [15:0] oe_cnt_q;
    logic [15:0] gap_q;

    // cycles the node has driven, and cycles nobody has driven (saturating)
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oe_cnt_q <= 16'h0000;
            gap_q <= 16'h0000;
        end else begin
            oe_cnt_q <= dev_oe ? oe_cnt_q + 16'h0001 : 16'h0000;
            gap_q <= (dev_oe || host_oe) ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hFFFF};
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_host_idle_high: assert property (!host_oe |-> host_out)
        else $error("master output low while released");
    a_released_high: assert property (!dev_oe |-> dev_out)
        else $error("node output low while released");
    a_no_overlap: assert property (!(dev_oe && host_oe))
        else $error("node drives while master drives");
    a_reply_delay: assert property ($rose(dev_oe) |-> gap_q >= 7 * BIT)
        else $error("reply started too soon");
    // sampling at bit centres keeps a one-cycle baud rounding harmless
    a_sync_frame: assert property (dev_oe && oe_cnt_q < 10 * BIT && oe_cnt_q % BIT == BIT / 2
        |-> dev_out == FRAME0[oe_cnt_q / BIT])
        else $error("first reply byte wrong");
    a_master_ones: assert property (dev_oe && oe_cnt_q inside {[11 * BIT + 2 : 20 * BIT - 2]}
        |-> dev_out)
        else $error("reply address byte not all ones");
    a_tail_high: assert property (dev_oe && oe_cnt_q > 80 * BIT + 2 |-> dev_out)
        else $error("tail not high");
    a_drive_length: assert property ($fell(dev_oe)
        |-> oe_cnt_q inside {[84 * BIT - BIT / 2 : 84 * BIT + BIT / 2]})
        else $error("node drive time wrong");

    c_reply_start: cover property ($rose(dev_oe));
    c_reply_end: cover property ($fell(dev_oe));
    c_master_frame: cover property ($fell(host_oe));
endmodule

/* File: single_wire_uart_read_crc_test.sv */
// self-checking bench: master and node joined on one resolved line
// assumes the master bit length stays above the node glitch filter
`timescale 1ns/1ps
module single_wire_uart_read_crc_test import swu_pkg::*; ;
    localparam int BIT = 20;
    localparam int LIMIT = 90000;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic sel0 = 1'b0, sel1 = 1'b0, wr_ready = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
    logic [3:0] dly = 4'h1;
    logic [7:0] cmd_node = 8'h00;
    logic [6:0] cmd_reg = 7'h00;
    logic [31:0] cmd_data = 32'h0000_0000;
    logic cmd_ready, rsp_valid, rsp_err, wr_valid;
    logic [31:0] rsp_data, rd_data, wr_data;
    logic [6:0] rd_addr, wr_reg;
    logic [7:0] cnt, own, c0;
    logic [38:0] wq[$];
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;

    // register contents seen by the node, a pattern tied to the address
    function automatic logic [31:0] reg_val(input logic [6:0] a);
        return {a, ~a, a, ~a, 4'h9};
    endfunction
    assign rd_data = reg_val(rd_addr);
    assign own = {6'h00, sel1, sel0};

    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    swu_if i_swu_if();
    swu_dev #(.FD(16)) i_swu_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(i_swu_if.dev),
        .i_node_sel_bit0_pin(sel0), .i_node_sel_bit1_pin(sel1), .i_reply_delay_setting(dly),
        .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_wr_valid(wr_valid),
        .i_wr_ready(wr_ready), .o_wr_reg(wr_reg), .o_wr_data(wr_data), .o_dgram_cnt(cnt));
    swu_host #(.BIT_CYC(BIT)) i_swu_host (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .bus(i_swu_if.host), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
        .i_cmd_write(cmd_write), .i_cmd_node(cmd_node), .i_cmd_reg(cmd_reg),
        .i_cmd_data(cmd_data), .o_rsp_valid(rsp_valid), .o_rsp_err(rsp_err),
        .o_rsp_data(rsp_data));
    swu_props #(.BIT(BIT)) i_swu_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .dev_out(i_swu_if.dev_out), .dev_oe(i_swu_if.dev_oe), .host_out(i_swu_if.host_out),
        .host_oe(i_swu_if.host_oe), .single_wire_data_pin(i_swu_if.single_wire_data_pin));

    task automatic check(input string what, input logic [38:0] seen, input logic [38:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one command through the valid/ready handshake; ends on a rising edge
    task automatic send(input logic w, input logic [7:0] node, input logic [6:0] r,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(negedge i_clk);
        while (cmd_ready !== 1'b1 && n < 200 * BIT) begin
            @(negedge i_clk);
            n++;
        end
        check("cmd_ready", cmd_ready, 1'b1);
        @(posedge i_clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_node <= node;
        cmd_reg <= r;
        cmd_data <= d;
        @(posedge i_clk);
        cmd_valid <= 1'b0;
    endtask

    task automatic do_read(input logic [7:0] node, input logic [6:0] r, input logic err);
        int n;
        @(posedge i_clk);
        // setting 0 must still give eight bits; one node only, so below two is legal
        dly <= 4'($urandom_range(3));
        @(negedge i_clk);
        c0 = cnt;
        send(1'b0, node, r, 32'h0000_0000);
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 300 * BIT);
        check("rsp_valid", rsp_valid, 1'b1);
        check("rsp_err", rsp_err, err);
        if (!err) check("rsp_data", rsp_data, reg_val(r));
        if (!err) check("rd_addr", rd_addr, r);
        check("count after read", cnt, c0);
        repeat (6 * BIT) @(posedge i_clk); // let the node finish its tail before reuse
    endtask

    // a hang ends the run through the same closing report
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(32'h357c));
        @(posedge i_clk);
        sel0 <= 1'($urandom);
        sel1 <= 1'($urandom);
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        do_read(own, 7'h7F, 1'b0);
        do_read(own, 7'h00, 1'b0);
        repeat (3) do_read(own, 7'($urandom), 1'b0);
        do_read(own ^ 8'h02, 7'h10, 1'b0 ^ 1'b1);
        do_read(8'hFF, 7'h10, 1'b1);
        @(negedge i_clk);
        c0 = cnt;
        send(1'b1, own ^ 8'h01, 7'h15, 32'h1234_5678);
        // fill the write queue with the consumer stalled
        for (int i = 0; i < 16; i++) begin
            logic [6:0] r;
            logic [31:0] d;
            r = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($urandom);
            d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $urandom;
            send(1'b1, own, r, d);
            wq.push_back({r, d});
        end
        repeat (90 * BIT) @(negedge i_clk);
        check("write count", cnt, c0 + 8'h10);
        // drain one entry at a time, oldest first
        while (wq.size() > 0) begin
            @(negedge i_clk);
            check("wr_valid", wr_valid, 1'b1);
            check("write entry", {wr_reg, wr_data}, wq.pop_front());
            @(posedge i_clk);
            wr_ready <= 1'b1;
            @(posedge i_clk);
            wr_ready <= 1'b0;
        end
        @(negedge i_clk);
        check("queue empty", wr_valid, 1'b0);
        complete_run();
    end
endmodule
